// ===== rtl/vcc_consts.vh
// Constants of the voice codec control block: offsets, fields, resets, timing
`ifndef VCC_CONSTS_VH
`define VCC_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VCC_ADDR_GAIN_ONE      3'h0
`define VCC_ADDR_GAIN_TWO      3'h1
`define VCC_ADDR_IFACE_CTRL    3'h3
`define VCC_ADDR_CODEC_TWO     3'h4
`define VCC_ADDR_STATUS        3'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define VCC_TXG_LSB            0
`define VCC_RXG_LSB            4
`define VCC_STG_LSB            0
`define VCC_ST_EN_BIT          3
`define VCC_LAW_BIT            0
`define VCC_SMAG_BIT           1
`define VCC_BUS_MODE_BIT       0
`define VCC_CHAN_LSB           3

// ****************************************************************
// Reset values
// ****************************************************************
`define VCC_RST_GAIN_ONE       8'h00
`define VCC_RST_GAIN_TWO       8'h00
`define VCC_RST_CODEC_TWO      8'h00
`define VCC_RST_IFACE_CTRL     8'h00

// ****************************************************************
// Timing and coding
// ****************************************************************
`define VCC_SLOT_BITS          4'h8
`define VCC_FRAME_HALF_BITS    9'h1ff
`define VCC_DLY_FRAME_HALF     9'h40
`define VCC_MU_MAG_MASK        8'h7f
`define VCC_A_MASK             8'h55
`define VCC_FIFO_WIDTH         8
`define VCC_FIFO_DEPTH         8
`define VCC_FIFO_AW            3

`endif

// ===== rtl/vcc_fifo.v
// Synchronous FIFO with valid/ready handshake on both sides
`timescale 1ns/1ns
module vcc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             reset_n,
  // Fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words
  reg [AW-1:0]    wr_ptr;           // Write index
  reg [AW-1:0]    rd_ptr;           // Read index
  reg [AW:0]      count;            // Words held
  wire            push;             // Accepted write
  wire            pop;              // Accepted read
  reg  [AW:0]     next_count;       // Count after this cycle

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // Next occupancy
  always @* begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      next_count = count - {{AW{1'b0}}, 1'b1};
    end
  end

  // Storage has no reset; only the flags and pointers need one
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and registered full/empty flags
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}}
                  : wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}}
                  : rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      count     <= next_count;
      in_ready  <= (next_count != DEPTH[AW:0]);
      out_valid <= (next_count != {(AW+1){1'b0}});
    end
  end

endmodule // vcc_fifo

// ===== rtl/vcc_top.v
// Voice codec control: PCM link, gain and law registers, cascade pulse
`timescale 1ns/1ns
`include "vcc_consts.vh"
module vcc_top (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       reset_n,
  // Register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // PCM link pins
  input  wire       master_clock_input,
  input  wire       slot_strobe_frame_pulse_in,
  input  wire       pcm_data_in,
  output reg        pcm_data_out,
  output reg        pcm_data_oe_n,
  output reg        delayed_strobe_pulse_out,
  // Law select pin
  input  wire       law_select_pin,
  // Transmit samples in sign-magnitude form
  input  wire [7:0] tx_sample,
  input  wire       tx_sample_valid,
  output wire       tx_sample_ready,
  // Received samples in sign-magnitude form
  output reg  [7:0] rx_sample,
  output reg        rx_sample_valid,
  // Controls toward the analog sections
  output reg  [2:0] tx_filter_gain_field,
  output reg  [2:0] rx_filter_gain_field,
  output reg  [2:0] sidetone_gain_field,
  output reg        sidetone_enable,
  output reg        alaw_active,
  output reg        coding_scheme_select,
  output reg        strobed_timeslot_mode
);

  // ****************************************************************
  // Code conversion
  // ****************************************************************

  // Maps sign-magnitude to line code; each mapping is its own inverse
  function [7:0] vcc_code;
    input [7:0] smag;
    input       smag_mode;
    input       alaw;
    begin
      if (smag_mode) begin
        vcc_code = smag;
      end else if (alaw) begin
        vcc_code = smag ^ `VCC_A_MASK;
      end else begin
        vcc_code = smag ^ `VCC_MU_MAG_MASK;
      end
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************

  reg  [7:0] gain_control_one;    // Transmit and receive gain
  reg  [7:0] gain_control_two;    // Side-tone gain and enable
  reg  [7:0] codec_control_two;   // Law and coding scheme
  reg  [7:0] interface_control;   // Port mode and bus channel
  wire       bus_mode;            // Frame-pulse bus mode selected
  wire [4:0] bus_channel;         // Channel used in bus mode
  wire       law_eff;             // Effective A-law selection
  wire [7:0] status_word;         // Live status bits

  assign bus_mode    = interface_control[`VCC_BUS_MODE_BIT];
  assign bus_channel = interface_control[`VCC_CHAN_LSB+4:`VCC_CHAN_LSB];
  assign law_eff     = codec_control_two[`VCC_LAW_BIT] | law_select_pin;

  // Register writes; reset restores the power-up defaults
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_control_one  <= `VCC_RST_GAIN_ONE;
      gain_control_two  <= `VCC_RST_GAIN_TWO;
      codec_control_two <= `VCC_RST_CODEC_TWO;
      interface_control <= `VCC_RST_IFACE_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `VCC_ADDR_GAIN_ONE: begin
          gain_control_one <= reg_wdata;
        end
        `VCC_ADDR_GAIN_TWO: begin
          gain_control_two <= reg_wdata;
        end
        `VCC_ADDR_IFACE_CTRL: begin
          interface_control <= reg_wdata;
        end
        `VCC_ADDR_CODEC_TWO: begin
          codec_control_two <= reg_wdata;
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Read data, registered one cycle after the strobe; unmapped reads as zero
  // Status reads have no side effects, so polling them is safe
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `VCC_ADDR_GAIN_ONE:   reg_rdata <= gain_control_one;
        `VCC_ADDR_GAIN_TWO:   reg_rdata <= gain_control_two;
        `VCC_ADDR_IFACE_CTRL: reg_rdata <= interface_control;
        `VCC_ADDR_CODEC_TWO:  reg_rdata <= codec_control_two;
        `VCC_ADDR_STATUS:     reg_rdata <= status_word;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // Analog control outputs follow the registers one cycle later
  // The one-cycle lag keeps these outputs straight off flip-flops
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_filter_gain_field  <= 3'h0;
      rx_filter_gain_field  <= 3'h0;
      sidetone_gain_field   <= 3'h0;
      sidetone_enable       <= 1'b0;
      alaw_active           <= 1'b0;
      coding_scheme_select  <= 1'b0;
      strobed_timeslot_mode <= 1'b1;
    end else begin
      tx_filter_gain_field  <= gain_control_one[`VCC_TXG_LSB+2:`VCC_TXG_LSB];
      rx_filter_gain_field  <= gain_control_one[`VCC_RXG_LSB+2:`VCC_RXG_LSB];
      sidetone_gain_field   <= gain_control_two[`VCC_STG_LSB+2:`VCC_STG_LSB];
      sidetone_enable       <= gain_control_two[`VCC_ST_EN_BIT];
      alaw_active           <= law_eff;
      coding_scheme_select  <= codec_control_two[`VCC_SMAG_BIT];
      strobed_timeslot_mode <= ~bus_mode;
    end
  end

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************

  wire [7:0] fifo_data;     // Head sample
  wire       fifo_valid;    // Head sample present
  reg        fifo_pop;      // Take head at slot start

  vcc_fifo #(
    .WIDTH (`VCC_FIFO_WIDTH),
    .DEPTH (`VCC_FIFO_DEPTH),
    .AW    (`VCC_FIFO_AW)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_data   (tx_sample),
    .in_valid  (tx_sample_valid),
    .in_ready  (tx_sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ****************************************************************
  // Link clock edges
  // ****************************************************************

  reg  mclk_q;    // Previous master clock level
  wire mclk_rise; // Bit clock rising edge
  wire mclk_fall; // Bit clock falling edge

  assign mclk_rise = master_clock_input & ~mclk_q;
  assign mclk_fall = ~master_clock_input & mclk_q;

  // Link pins are synchronous to sys_clk, so one stage suffices for edges
  // Each master clock level must last one sys_clk, or an edge is lost
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mclk_q <= 1'b0;
    end else begin
      mclk_q <= master_clock_input;
    end
  end

  // ****************************************************************
  // Slot timing
  // ****************************************************************

  reg  [8:0] half_cnt;     // Bus mode: master clock rises since frame
  reg        in_slot;      // Own slot is active
  reg  [3:0] tx_cnt;       // Bits driven in this slot
  reg  [3:0] rx_cnt;       // Bits sampled in this slot
  reg  [7:0] tx_shift;     // Outgoing line code
  reg  [7:0] rx_shift;     // Incoming line code
  reg  [3:0] dly_cnt;      // Delayed strobe bits left
  wire       bus_slot;     // Bus counter inside own channel
  wire       slot_req;     // Slot request for the current mode
  wire [7:0] quiet_smag;   // Negative zero, sent when starved
  wire [7:0] tx_line;      // Line code loaded at slot start

  assign quiet_smag = 8'h00;
  assign tx_line    = vcc_code(fifo_valid ? fifo_data : quiet_smag,
                               codec_control_two[`VCC_SMAG_BIT], law_eff);
  // Bus bit index is half_cnt/2; own channel covers eight of them
  assign bus_slot   = (half_cnt[8:4] == bus_channel);
  assign slot_req   = bus_mode ? bus_slot : slot_strobe_frame_pulse_in;
  assign status_word = {5'h00, in_slot, fifo_valid, law_eff};

  // Bus frame counter, restarted by the active-low frame pulse
  // It also runs in strobe mode, where the low strobe keeps clearing it;
  // only bus mode reads it, so that extra activity is harmless
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      half_cnt <= 9'h000;
    end else if (mclk_rise) begin
      if (!slot_strobe_frame_pulse_in) begin
        half_cnt <= 9'h000;
      end else if (half_cnt == `VCC_FRAME_HALF_BITS) begin
        half_cnt <= 9'h000;
      end else begin
        half_cnt <= half_cnt + 9'h001;
      end
    end
  end

  // Transmit shifter: one byte per frame, bits change on the rise
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_slot       <= 1'b0;
      tx_cnt        <= 4'h0;
      tx_shift      <= 8'h00;
      pcm_data_out  <= 1'b0;
      pcm_data_oe_n <= 1'b1;
      fifo_pop      <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      if (mclk_rise && (!bus_mode || !half_cnt[0])) begin
        if (slot_req && !in_slot) begin
          // Slot start: load the next sample, or the quiet code if starved
          in_slot       <= 1'b1;
          tx_cnt        <= 4'h1;
          // The MSB leaves now, so the shifter keeps only the other seven bits
          tx_shift      <= {tx_line[6:0], 1'b0};
          pcm_data_out  <= tx_line[7];
          pcm_data_oe_n <= 1'b0;
          fifo_pop      <= fifo_valid;
        end else if (slot_req && tx_cnt != `VCC_SLOT_BITS) begin
          tx_cnt        <= tx_cnt + 4'h1;
          pcm_data_out  <= tx_shift[7];
          tx_shift      <= {tx_shift[6:0], 1'b0};
        end else begin
          // Outside the slot the line is released for other devices
          pcm_data_oe_n <= 1'b1;
          in_slot       <= slot_req;
          tx_cnt        <= slot_req ? tx_cnt : 4'h0;
        end
      end
    end
  end

  // Receive shifter: bits sampled on the fall inside the slot
  // A slot cut short by the strobe leaves the count short and hands nothing
  // over, which is safer than passing on a torn byte
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt          <= 4'h0;
      rx_shift        <= 8'h00;
      rx_sample       <= 8'h00;
      rx_sample_valid <= 1'b0;
    end else begin
      rx_sample_valid <= 1'b0;
      if (mclk_fall && (!bus_mode || half_cnt[0])) begin
        if (in_slot && rx_cnt != `VCC_SLOT_BITS) begin
          rx_shift <= {rx_shift[6:0], pcm_data_in};
          rx_cnt   <= rx_cnt + 4'h1;
          if (rx_cnt == `VCC_SLOT_BITS - 4'h1) begin
            rx_sample       <= vcc_code({rx_shift[6:0], pcm_data_in},
                                        codec_control_two[`VCC_SMAG_BIT], law_eff);
            rx_sample_valid <= 1'b1;
          end
        end else if (!in_slot) begin
          rx_cnt <= 4'h0;
        end
      end
    end
  end

  // ****************************************************************
  // Cascade pulse
  // ****************************************************************

  // Strobe mode: eight bit-wide high strobe once the input strobe drops.
  // Bus mode: active-low pulse one bus clock wide, four channels later.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_cnt                  <= 4'h0;
      delayed_strobe_pulse_out <= 1'b0;
    end else if (bus_mode) begin
      dly_cnt <= 4'h0;
      // Active low, idling high from the first bus clock fall on
      if (mclk_fall) begin
        delayed_strobe_pulse_out <=
          (half_cnt != `VCC_DLY_FRAME_HALF - 9'h001);
      end
    end else if (mclk_rise) begin
      if (in_slot && !slot_strobe_frame_pulse_in) begin
        dly_cnt                  <= `VCC_SLOT_BITS - 4'h1;
        delayed_strobe_pulse_out <= 1'b1;
      end else if (dly_cnt != 4'h0) begin
        dly_cnt <= dly_cnt - 4'h1;
      end else begin
        delayed_strobe_pulse_out <= 1'b0;
      end
    end
  end

endmodule // vcc_top

// ===== tb/tb.sv
// Self-checking bench for the voice codec control block
`timescale 1ns/1ns
module tb;
  reg        sys_clk, reset_n, reg_wr, reg_rd, law_select_pin, tx_sample_valid;
  reg  [2:0] reg_addr;
  reg  [7:0] reg_wdata, tx_sample, rx_seen, v;
  wire [7:0] reg_rdata, rx_sample;
  wire [2:0] txg, rxg, stg;
  wire       mclk, strb, din, dout, oe_n, dly, ready, rx_valid, st_en, alaw, coding, ssm;
  integer    err_total, n_checks, s, i;
  reg  [7:0] codes [0:3]; // Sign-magnitude +FS, +0, -0, -FS
  reg  [7:0] lines [0:15]; // Line codes of +FS, +0, -0, -FS: mu, A, sign-mag, A by pin
  integer    n_rx = 0;     // Decoded samples handed over
  vcc_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_clock_input(mclk), .slot_strobe_frame_pulse_in(strb), .pcm_data_in(din),
    .pcm_data_out(dout), .pcm_data_oe_n(oe_n), .delayed_strobe_pulse_out(dly),
    .law_select_pin(law_select_pin), .tx_sample(tx_sample), .tx_sample_valid(tx_sample_valid),
    .tx_sample_ready(ready), .rx_sample(rx_sample), .rx_sample_valid(rx_valid),
    .tx_filter_gain_field(txg), .rx_filter_gain_field(rxg), .sidetone_gain_field(stg),
    .sidetone_enable(st_en), .alaw_active(alaw), .coding_scheme_select(coding),
    .strobed_timeslot_mode(ssm));
  vcc_xcvr_model i_xcvr (.sys_clk(sys_clk), .pcm_data_out(dout), .pcm_data_oe_n(oe_n),
    .delayed_strobe_pulse_out(dly), .master_clock_input(mclk),
    .slot_strobe_frame_pulse_in(strb), .pcm_data_in(din));
  // Clock at 250 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Keep the last decoded sample
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      rx_seen <= rx_sample;
      n_rx    <= n_rx + 1;
    end
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  task chk(input [8*12-1:0] name, input [7:0] exp, input [7:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task chk_n(input [8*12-1:0] name, input integer exp, input integer got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("mismatch %0s expected %0d seen %0d", name, exp, got);
      end
    end
  endtask
  // One-cycle write strobe, then two idle cycles
  task wr(input [2:0] a, input [7:0] d);
    begin
      reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
      @(negedge sys_clk); reg_wr = 1'b0;
      repeat (2) @(negedge sys_clk);
    end
  endtask
  // Read data is taken one cycle after the read edge
  task rd(input [2:0] a, output [7:0] d);
    begin
      reg_addr = a; reg_rd = 1'b1;
      @(negedge sys_clk); reg_rd = 1'b0;
      @(negedge sys_clk); d = reg_rdata;
    end
  endtask
  // Offer one sample; valid stays up for the caller to drop
  task push(input [7:0] d);
    begin
      tx_sample = d; tx_sample_valid = 1'b1;
      // Ready is read at the falling edge, where it has settled
      while (ready !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
    end
  endtask
  // Frame carrying one sample each way: code in sign-magnitude, line on the wire
  task frame(input [7:0] code, input [7:0] line);
    reg [7:0] got;
    integer   n0;
    begin
      n0 = n_rx;
      i_xcvr.run_frame(line, got);
      chk("tx code", line, got);
      chk("rx sample", code, rx_seen);
      chk_n("rx count", n0 + 1, n_rx);
      chk_n("slot bits", 8, i_xcvr.oe_bits);
      chk_n("dly bits", 8, i_xcvr.dly_bits);
    end
  endtask
  // Watchdog well beyond the planned run
  initial begin
    #100000;
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    codes[0] = 8'hff; codes[1] = 8'h80; codes[2] = 8'h00; codes[3] = 8'h7f;
    lines[0] = 8'h80; lines[1] = 8'hff; lines[2] = 8'h7f; lines[3] = 8'h00;
    lines[4] = 8'haa; lines[5] = 8'hd5; lines[6] = 8'h55; lines[7] = 8'h2a;
    lines[8] = 8'hff; lines[9] = 8'h80; lines[10] = 8'h00; lines[11] = 8'h7f;
    lines[12] = 8'haa; lines[13] = 8'hd5; lines[14] = 8'h55; lines[15] = 8'h2a;
    err_total = 0; n_checks = 0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 3'h0; reg_wdata = 8'h00; law_select_pin = 1'b0;
    tx_sample = 8'h00; tx_sample_valid = 1'b0;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    // Defaults after power-up reset
    rd(3'h0, v); chk("gain one", 8'h00, v);
    rd(3'h1, v); chk("gain two", 8'h00, v);
    rd(3'h4, v); chk("codec two", 8'h00, v);
    chk("mode", 8'h01, {7'h00, ssm});
    // Gain fields set to transmit 5, receive 7, side-tone 6 with enable
    wr(3'h0, 8'h75); rd(3'h0, v); chk("gain one", 8'h75, v);
    chk("tx gain", 8'h05, {5'h00, txg});
    chk("rx gain", 8'h07, {5'h00, rxg});
    wr(3'h1, 8'h0e); chk("side-tone", 8'h0e, {4'h0, st_en, stg});
    // Unmapped place keeps nothing
    wr(3'h2, 8'hff); rd(3'h2, v); chk("unmapped", 8'h00, v);
    // Fill the FIFO until it refuses; the ninth value must never appear
    for (i = 0; i < 8; i = i + 1) push(codes[i%4]);
    tx_sample = 8'h11;
    @(negedge sys_clk);
    chk("ready full", 8'h00, {7'h00, ready});
    tx_sample_valid = 1'b0;
    // Each coding setting carries all four table codes
    for (s = 0; s < 4; s = s + 1) begin
      wr(3'h4, (s == 1) ? 8'h01 : (s == 2) ? 8'h02 : 8'h00);
      law_select_pin = (s == 3);
      repeat (3) @(negedge sys_clk);
      rd(3'h5, v); chk("eff law", (s == 1 || s == 3) ? 8'h01 : 8'h00, v & 8'h01);
      chk("coding", (s == 2) ? 8'h01 : 8'h00, {7'h00, coding});
      chk("alaw out", (s == 1 || s == 3) ? 8'h01 : 8'h00, {7'h00, alaw});
      if (s > 0) begin
        for (i = 0; i < 4; i = i + 1) push(codes[i]);
        tx_sample_valid = 1'b0;
      end
      for (i = 0; i < ((s == 0) ? 8 : 4); i = i + 1) frame(codes[i%4], lines[4*s+i%4]);
    end
    // Empty FIFO sends negative zero of the active law
    frame(8'h00, 8'h55);
    // Bus mode on channel 1, still A-law by pin
    wr(3'h3, 8'h09);
    chk("mode", 8'h00, {7'h00, ssm});
    push(8'hff);
    tx_sample_valid = 1'b0;
    i_xcvr.run_bus(8'hd5, v);
    chk("bus tx", 8'haa, v);
    chk("bus rx", 8'h80, rx_seen);
    chk_n("bus slot", 8, i_xcvr.oe_bits);
    chk_n("bus dly pos", 64, i_xcvr.dly_bits);
    // Reset in mid-run restores the defaults
    law_select_pin = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    rd(3'h0, v); chk("gain one", 8'h00, v);
    rd(3'h4, v); chk("codec two", 8'h00, v);
    rd(3'h3, v); chk("iface", 8'h00, v);
    chk("mode", 8'h01, {7'h00, ssm});
    print_verdict;
  end
endmodule // tb
bind vcc_top vcc_monitor i_mon (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .law_select_pin, .pcm_data_oe_n, .delayed_strobe_pulse_out, .tx_sample_valid,
  .tx_sample_ready, .rx_sample_valid, .tx_filter_gain_field, .rx_filter_gain_field,
  .sidetone_gain_field, .sidetone_enable, .alaw_active, .coding_scheme_select,
  .strobed_timeslot_mode);

// ===== tb/vcc_monitor.sv
// Port checker for the voice codec control block
`timescale 1ns/1ns
module vcc_monitor (
  // Clock and reset
  input wire       sys_clk,
  input wire       reset_n,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Link and sample side
  input wire       law_select_pin,
  input wire       pcm_data_oe_n,
  input wire       delayed_strobe_pulse_out,
  input wire       tx_sample_valid,
  input wire       tx_sample_ready,
  input wire       rx_sample_valid,
  // Analog controls
  input wire [2:0] tx_filter_gain_field,
  input wire [2:0] rx_filter_gain_field,
  input wire [2:0] sidetone_gain_field,
  input wire       sidetone_enable,
  input wire       alaw_active,
  input wire       coding_scheme_select,
  input wire       strobed_timeslot_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Write at one address, then two quiet edges so the output has settled
  sequence wr_at(a);
    (reg_wr && reg_addr == a) ##1 !reg_wr ##1 !reg_wr;
  endsequence
  txg_follow_a: assert property (wr_at(3'h0) |->
    {5'h00, tx_filter_gain_field} == ($past(reg_wdata, 2) & 8'h07)) else $error("tx gain stale");
  rxg_follow_a: assert property (wr_at(3'h0) |->
    {1'b0, rx_filter_gain_field, 4'h0} == ($past(reg_wdata, 2) & 8'h70)) else $error("rx gain stale");
  side_follow_a: assert property (wr_at(3'h1) |->
    {4'h0, sidetone_enable, sidetone_gain_field} == ($past(reg_wdata, 2) & 8'h0f))
    else $error("side-tone control stale");
  coding_follow_a: assert property (wr_at(3'h4) |->
    {6'h00, coding_scheme_select, 1'b0} == ($past(reg_wdata, 2) & 8'h02)) else $error("coding stale");
  law_pin_or_a: assert property (law_select_pin [*3] |-> alaw_active)
    else $error("law pin ignored");
  reset_default_a: assert property ($rose(reset_n) |-> strobed_timeslot_mode &&
    !sidetone_enable && !coding_scheme_select && tx_filter_gain_field == 3'h0) else $error("bad default");
  out_release_a: assert property (strobed_timeslot_mode && delayed_strobe_pulse_out &&
    $past(delayed_strobe_pulse_out) |-> pcm_data_oe_n) else $error("data driven outside slot");
  rx_pulse_a: assert property (rx_sample_valid |=> !rx_sample_valid)
    else $error("rx valid too long");
  ready_hold_a: assert property (tx_sample_ready && !tx_sample_valid |=> tx_sample_ready)
    else $error("ready fell without push");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 3'h2 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Main scenarios reached
  rx_seen_c: cover property (rx_sample_valid);
  dly_seen_c: cover property ($rose(delayed_strobe_pulse_out));
  full_seen_c: cover property ($fell(tx_sample_ready));
  bus_pulse_c: cover property (!strobed_timeslot_mode && $fell(delayed_strobe_pulse_out));
endmodule // vcc_monitor

// ===== tb/vcc_xcvr_model.sv
// Line transceiver model: bit clock, slot strobe and serial PCM
`timescale 1ns/1ns
module vcc_xcvr_model (
  // Clock
  input  wire sys_clk,
  // From the block
  input  wire pcm_data_out,
  input  wire pcm_data_oe_n,
  input  wire delayed_strobe_pulse_out,
  // To the block
  output reg  master_clock_input,
  output reg  slot_strobe_frame_pulse_in,
  output reg  pcm_data_in
);
  integer dly_bits; // Frame run: falls seen with delayed strobe high; bus run: sum of rises seen low
  integer oe_bits;  // Falls seen with data driven; bus run counts them at odd rises only
  initial begin
    master_clock_input = 1'b0;
    slot_strobe_frame_pulse_in = 1'b0;
    pcm_data_in = 1'b0;
  end
  // One frame: 2 idle bits, 8 slot bits, 10 trailing bits; clock still between frames
  // Each level lasts 4 sys_clk, above the 1 cycle the sampler needs
  task run_frame(input [7:0] send, output [7:0] got);
    integer k;
    begin
      dly_bits = 0;
      oe_bits = 0;
      got = 8'h00;
      for (k = 0; k < 20; k = k + 1) begin
        slot_strobe_frame_pulse_in = (k >= 2 && k < 10);
        repeat (4) @(negedge sys_clk);
        master_clock_input = 1'b1;
        // Slot bits change on the rise; outside, the line toggles as no one holds it
        pcm_data_in = (k >= 2 && k < 10) ? send[9-k] : ~pcm_data_in;
        repeat (4) @(negedge sys_clk);
        if (pcm_data_oe_n === 1'b0) begin
          got = {got[6:0], pcm_data_out};
          oe_bits = oe_bits + 1;
        end
        if (delayed_strobe_pulse_out === 1'b1) dly_bits = dly_bits + 1;
        master_clock_input = 1'b0;
      end
    end
  endtask
  // Bus frame on channel 1: frame pulse low at the first rise of the
  // double-rate bus clock one bit every two rises, taken at odd rises
  task run_bus(input [7:0] send, output [7:0] got);
    integer k;
    begin
      dly_bits = 0;
      oe_bits = 0;
      got = 8'h00;
      for (k = 0; k < 68; k = k + 1) begin
        slot_strobe_frame_pulse_in = (k != 0);
        repeat (4) @(negedge sys_clk);
        master_clock_input = 1'b1;
        pcm_data_in = (k >= 17 && k < 32 && k % 2 == 1) ? send[7-(k-17)/2] : ~pcm_data_in;
        repeat (4) @(negedge sys_clk);
        if (pcm_data_oe_n === 1'b0 && k % 2 == 1) begin
          got = {got[6:0], pcm_data_out};
          oe_bits = oe_bits + 1;
        end
        // Sum of the rise numbers at which the delayed pulse is seen low
        if (k > 0 && delayed_strobe_pulse_out === 1'b0) dly_bits = dly_bits + k;
        master_clock_input = 1'b0;
      end
    end
  endtask
endmodule // vcc_xcvr_model
